// ==== rtl/mcc_defs.svh ====
`ifndef MCC_DEFS_SVH
`define MCC_DEFS_SVH
// ------------------------------------------------------------
// Register map (word index on the plain port)
// ------------------------------------------------------------
`define MCC_A_CMD 6'h00
`define MCC_A_RES 6'h01
`define MCC_A_T1 6'h02
`define MCC_A_T2 6'h03
`define MCC_A_TI 6'h04
`define MCC_A_DACA 6'h01
`define MCC_A_AUTO 6'h08
`define MCC_A_STAT 6'h05
`define MCC_A_CLR 6'h06
`define MCC_A_OFS1 6'h26
`define MCC_A_OFS2 6'h27
// ------------------------------------------------------------
// Fields and timing
// ------------------------------------------------------------
`define MCC_TSEL_R1 1'b1
`define MCC_CMD_R1_BIT 3'd6
`define MCC_CMD_R2_BIT 3'd7
`define MCC_PERIOD_US 5000
`define MCC_CLK_MHZ 200
`define MCC_CMD_RST 8'h00
`define MCC_CMD_CONV_MASK 8'h3f
`endif

// ==== rtl/mcc_pkg.sv ====
package mcc_pkg;
   typedef enum logic [1:0] {
      MCC_IDLE = 2'b00,
      MCC_CONV = 2'b01,
      MCC_TEMP = 2'b11
   } mcc_state_t;
   typedef enum logic [1:0] {
      MCC_T_LOCAL = 2'b00,
      MCC_T_REM1 = 2'b01,
      MCC_T_REM2 = 2'b10
   } mcc_tch_t;
endpackage

// ==== rtl/mcc_integrator.sv ====
`timescale 1ns/1ps
`include "mcc_defs.svh"
// ------------------------------------------------------------
// Background integration sequencer
// ------------------------------------------------------------
module mcc_integrator
   import mcc_pkg::*;
#(
   parameter int unsigned SLOT_CYC = 333333
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   output logic done_o,
   output mcc_tch_t ch_o
);
   logic [31:0] cnt_q;
   mcc_tch_t act_q;
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cnt_q <= 32'h0;
         done_o <= 1'b0;
         act_q <= MCC_T_LOCAL;
         ch_o <= MCC_T_LOCAL;
      end else begin
         done_o <= 1'b0;
         if (cnt_q == SLOT_CYC - 1) begin
            cnt_q <= 32'h0;
            done_o <= 1'b1;
            // Report the channel that just finished
            ch_o <= act_q;
            act_q <= (act_q == MCC_T_REM2) ? MCC_T_LOCAL : mcc_tch_t'(act_q + 2'd1);
         end else begin
            cnt_q <= cnt_q + 32'd1;
         end
      end
   end
endmodule

// ==== rtl/mcc_ctrl.sv ====
`timescale 1ns/1ps
`include "mcc_defs.svh"
module mcc_ctrl
   import mcc_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = `MCC_PERIOD_US * `MCC_CLK_MHZ,
   parameter int unsigned DW = 12
) (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic autocycle_i,
   output logic adc_start_o,
   output logic adc_temp_o,
   output logic [1:0] adc_tch_o,
   input wire logic adc_done_i,
   input wire logic [DW-1:0] adc_data_i,
   input wire logic [1:0] shunt_over_i,
   input wire logic [1:0] supply_low_i,
   output logic [1:0] current_overrange_flag_o,
   output logic [4*DW-1:0] dac_tap_o
);
   // ------------------------------------------------------------
   // Integration sequencer
   // ------------------------------------------------------------
   localparam int unsigned SLOT = PERIOD_CYC / 3;
   logic int_done;
   mcc_tch_t int_ch;
   mcc_integrator #(.SLOT_CYC(SLOT)) u_int (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .done_o(int_done),
      .ch_o(int_ch)
   );
   // ------------------------------------------------------------
   // Scheduler
   // ------------------------------------------------------------
   mcc_state_t state_q;
   logic [2:0] pend_q;
   logic cmd_start;
   logic [DW-1:0] tres_q [3];
   logic [DW-1:0] ofs_q [2];
   logic [7:0] cmd_q;
   logic [2:0] seq_q;
   logic [1:0] sel_q;
   logic [1:0] cur_ch;

   function automatic logic [1:0] first_pend(input logic [2:0] p);
      if (p[0]) return 2'd0;
      else if (p[1]) return 2'd1;
      else return 2'd2;
   endfunction

   // Remote-only selections start nothing
   assign cmd_start = wr_i && (addr_i == `MCC_A_CMD) &&
      ((wdata_i[7:0] & `MCC_CMD_CONV_MASK) != 8'h00);
   assign cur_ch = first_pend(pend_q);

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         pend_q <= 3'h0;
      end else begin
         // Set wins over the serve clear
         for (int i = 0; i < 3; i++) begin
            if (int_done && int_ch == i) pend_q[i] <= 1'b1;
            else if (state_q == MCC_TEMP && adc_done_i && sel_q == i) pend_q[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_q <= MCC_IDLE;
         adc_start_o <= 1'b0;
         adc_temp_o <= 1'b0;
         adc_tch_o <= 2'h0;
         sel_q <= 2'h0;
      end else begin
         adc_start_o <= 1'b0;
         case (state_q)
            MCC_IDLE: begin
               if (pend_q != 3'h0) begin
                  state_q <= MCC_TEMP;
                  adc_start_o <= 1'b1;
                  adc_temp_o <= 1'b1;
                  adc_tch_o <= cur_ch;
                  sel_q <= cur_ch;
               end else if (cmd_start || autocycle_i) begin
                  state_q <= MCC_CONV;
                  adc_start_o <= 1'b1;
                  adc_temp_o <= 1'b0;
               end
            end
            MCC_CONV: begin
               // Temperature slots in after the running conversion
               if (adc_done_i) begin
                  if (pend_q != 3'h0) begin
                     state_q <= MCC_TEMP;
                     adc_start_o <= 1'b1;
                     adc_temp_o <= 1'b1;
                     adc_tch_o <= cur_ch;
                     sel_q <= cur_ch;
                  end else begin
                     state_q <= MCC_IDLE;
                  end
               end
            end
            MCC_TEMP: begin
               if (adc_done_i) begin
                  state_q <= MCC_IDLE;
                  adc_temp_o <= 1'b0;
               end
            end
            default: state_q <= MCC_IDLE;
         endcase
      end
   end
   // ------------------------------------------------------------
   // Results, with offset correction on the remote channels only
   // ------------------------------------------------------------
   function automatic logic [DW-1:0] add_ofs(input logic [DW-1:0] v, input logic [DW-1:0] o);
      return v + o;
   endfunction

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 3; i++) tres_q[i] <= '0;
      end else if (state_q == MCC_TEMP && adc_done_i) begin
         // Whole word in one edge
         case (sel_q)
            2'd1: tres_q[1] <= add_ofs(adc_data_i, ofs_q[0]);
            2'd2: tres_q[2] <= add_ofs(adc_data_i, ofs_q[1]);
            default: tres_q[0] <= adc_data_i;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         ofs_q[0] <= '0;
         ofs_q[1] <= '0;
      end else if (wr_i) begin
         if (addr_i == `MCC_A_OFS1) ofs_q[0] <= wdata_i[DW-1:0];
         if (addr_i == `MCC_A_OFS2) ofs_q[1] <= wdata_i[DW-1:0];
      end
   end
   // ------------------------------------------------------------
   // Command read sequence
   // ------------------------------------------------------------
   function automatic logic [2:0] next_sel(input logic [7:0] m, input logic [2:0] from);
      logic [2:0] r;
      r = from;
      for (int k = 7; k >= 0; k--) begin
         if (m[k] && k > from) r = 3'(k);
      end
      if (r == from) begin
         for (int k = 7; k >= 0; k--) begin
            if (m[k]) r = 3'(k);
         end
      end
      return r;
   endfunction

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         cmd_q <= `MCC_CMD_RST;
         seq_q <= 3'h0;
      end else if (wr_i && addr_i == `MCC_A_CMD) begin
         cmd_q <= wdata_i[7:0];
         seq_q <= next_sel(wdata_i[7:0], 3'd7);
      end else if (rd_i && addr_i == `MCC_A_RES) begin
         seq_q <= next_sel(cmd_q, seq_q);
      end
   end
   // ------------------------------------------------------------
   // Overrange latches
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         current_overrange_flag_o <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (shunt_over_i[i] || supply_low_i[i])
               current_overrange_flag_o[i] <= 1'b1;
            else if (wr_i && addr_i == `MCC_A_CLR && wdata_i[i])
               current_overrange_flag_o[i] <= 1'b0;
         end
      end
   end
   // ------------------------------------------------------------
   // DAC codes and taps
   // ------------------------------------------------------------
   logic [DW-1:0] dac_q [4];
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 4; i++) dac_q[i] <= '0;
      end else if (wr_i) begin
         for (int i = 0; i < 4; i++) begin
            if (addr_i == `MCC_A_DACA + 6'(i)) dac_q[i] <= wdata_i[DW-1:0];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         dac_tap_o <= {4*DW{1'b1}};
      end else begin
         for (int i = 0; i < 4; i++) dac_tap_o[i*DW +: DW] <= ~dac_q[i];
      end
   end
   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0;
      end else if (rd_i) begin
         case (addr_i)
            `MCC_A_RES: begin
               if (seq_q == `MCC_CMD_R1_BIT && cmd_q[seq_q]) rdata_o <= 16'(tres_q[1]);
               else if (seq_q == `MCC_CMD_R2_BIT && cmd_q[seq_q]) rdata_o <= 16'(tres_q[2]);
               else rdata_o <= 16'h0;
            end
            `MCC_A_T1: rdata_o <= 16'(tres_q[1]);
            `MCC_A_T2: rdata_o <= 16'(tres_q[2]);
            `MCC_A_TI: rdata_o <= 16'(tres_q[0]);
            `MCC_A_STAT: rdata_o <= {14'h0, current_overrange_flag_o};
            `MCC_A_OFS1: rdata_o <= 16'(ofs_q[0]);
            `MCC_A_OFS2: rdata_o <= 16'(ofs_q[1]);
            default: rdata_o <= 16'h0;
         endcase
      end else begin
         rdata_o <= 16'h0;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_idle_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == MCC_IDLE && pend_q != 3'h0 |=> adc_start_o && adc_temp_o)
      else $error("pending temp not started from idle");
   a_one_conv: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      adc_start_o |-> state_q != MCC_IDLE)
      else $error("start without busy state");
   a_cmd_follow: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == MCC_CONV && adc_done_i && pend_q != 3'h0 |=> adc_start_o && adc_temp_o)
      else $error("temp not run after conversion");
   a_pend_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      int_done |=> pend_q != 3'h0)
      else $error("integration request lost");
   a_over_latch: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      current_overrange_flag_o[0] && !(wr_i && addr_i == `MCC_A_CLR)
      |=> current_overrange_flag_o[0])
      else $error("overrange dropped without clear");
   a_over_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      shunt_over_i[1] || supply_low_i[1] |=> current_overrange_flag_o[1])
      else $error("overrange not raised");
   a_dac_inv: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `MCC_A_DACA |=> ##1 dac_tap_o[DW-1:0] == ~$past(wdata_i[DW-1:0], 2))
      else $error("dac tap not inverted code");
   a_res_upd: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      state_q == MCC_TEMP && adc_done_i && sel_q == 2'd1
      |=> tres_q[1] == $past(adc_data_i) + $past(ofs_q[0]))
      else $error("remote result not offset");
   a_remote_noconv: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `MCC_A_CMD && (wdata_i[7:0] & `MCC_CMD_CONV_MASK) == 8'h00
      && state_q == MCC_IDLE && pend_q == 3'h0 && !autocycle_i |=> !adc_start_o)
      else $error("remote selection started a conversion");
   a_seq_sel: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `MCC_A_CMD && wdata_i[7:0] != `MCC_CMD_RST |=> cmd_q[seq_q])
      else $error("sequence points at unselected channel");
   a_res_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !(state_q == MCC_TEMP && adc_done_i) |=> $stable(tres_q[2]))
      else $error("result changed without conversion");
   a_dac_last: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `MCC_A_DACA + 6'h03
      |=> ##1 dac_tap_o[4*DW-1:3*DW] == ~$past(wdata_i[DW-1:0], 2))
      else $error("last dac tap not inverted code");
   a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      wr_i && addr_i == `MCC_A_CLR && wdata_i[1] && !shunt_over_i[1] && !supply_low_i[1]
      |=> !current_overrange_flag_o[1])
      else $error("overrange latch not cleared");
endmodule

// ==== sim/mcc_adc_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Shared converter core, prompt or slow
// ------------------------------------------------------------
module mcc_adc_model (
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   input wire logic slow_i,
   input wire logic start_i,
   output logic done_o,
   output logic [11:0] data_o,
   output int overlap_o
);
   int seed = 20621;
   int wait_q;
   logic busy_q;
   always @(posedge ref_clk_i) begin
      done_o <= 1'b0;
      // Released data lines toggle
      data_o <= ~data_o;
      if (!rstn_i) begin
         busy_q <= 1'b0;
         overlap_o <= 0;
         data_o <= 12'h000;
      end else if (start_i && busy_q) begin
         overlap_o <= overlap_o + 1;
      end else if (start_i) begin
         busy_q <= 1'b1;
         wait_q <= slow_i ? 10 + ($random(seed) & 31) : 2;
      end else if (busy_q && wait_q > 0) begin
         wait_q <= wait_q - 1;
      end else if (busy_q) begin
         busy_q <= 1'b0;
         done_o <= 1'b1;
         data_o <= 12'($random(seed));
      end
   end
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
   import mcc_pkg::*;
   localparam int unsigned PER = 300;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   logic auto = 1'b0;
   logic slow = 1'b0;
   logic [1:0] shunt = 2'b00;
   logic [1:0] sup = 2'b00;
   logic [15:0] rdata;
   logic start;
   logic temp;
   logic [1:0] tch;
   logic done;
   logic [11:0] adata;
   logic [1:0] flag;
   logic [47:0] tap;
   logic [47:0] exp_tap = {48{1'b1}};
   logic [15:0] exp_q[$];
   logic [11:0] ofs[3] = '{12'h000, 12'h000, 12'h000};
   logic [11:0] res[3];
   logic [11:0] codes[4];
   int seed = 20621;
   int ovl;
   int n_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int tcount = 0;
   int c0;

   mcc_ctrl #(.PERIOD_CYC(PER)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .autocycle_i(auto),
      .adc_start_o(start), .adc_temp_o(temp), .adc_tch_o(tch), .adc_done_i(done),
      .adc_data_i(adata), .shunt_over_i(shunt), .supply_low_i(sup),
      .current_overrange_flag_o(flag), .dac_tap_o(tap));
   mcc_adc_model adc_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .slow_i(slow),
      .start_i(start), .done_o(done), .data_o(adata), .overlap_o(ovl));

   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // ------------------------------------------------------------
   // Compare, bus tasks, verdict
   // ------------------------------------------------------------
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
      @(posedge ref_clk_i);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk_i);
      rd <= 1'b0;
   endtask
   task automatic wait_temp(input logic [1:0] ch);
      int k;
      k = 0;
      do begin
         @(negedge ref_clk_i);
         k++;
      end while (!(done === 1'b1 && temp === 1'b1 && tch === ch) && k < 2000);
      if (k >= 2000) begin
         n_errors++;
         $display("BAD %0t no temperature result", $time);
      end
      res[ch] = adata + ofs[ch];
   endtask
   task automatic run_temps();
      wait_temp(2'd0);
      rd_reg(6'h04, {4'h0, res[0]});
      wait_temp(2'd1);
      rd_reg(6'h02, {4'h0, res[1]});
      wait_temp(2'd2);
      rd_reg(6'h03, {4'h0, res[2]});
      c0 = tcount;
      repeat (3 * PER) @(posedge ref_clk_i);
      chk((tcount - c0) inside {[8:10]}, 1);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Read watcher and timeout
   // ------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      rd_d <= rd;
      cyc <= cyc + 1;
      if (done && temp) begin
         tcount <= tcount + 1;
      end
      if (cyc == 20000) begin
         n_errors++;
         $display("BAD %0t run did not finish", $time);
         end_of_test();
      end
   end
   always @(negedge ref_clk_i) begin
      if (rd_d && exp_q.size() > 0) begin
         chk(rdata, exp_q.pop_front());
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      @(negedge ref_clk_i);
      chk(tap, exp_tap);
      chk(flag, 2'b00);
      codes = '{12'h000, 12'hfff, 12'($random(seed)), 12'($random(seed))};
      for (int i = 0; i < 4; i++) begin
         wr_reg(6'h01 + 6'(i), {4'h0, codes[i]});
         exp_tap[12*i +: 12] = ~codes[i];
         @(posedge ref_clk_i);
         @(negedge ref_clk_i);
         chk(tap, exp_tap);
      end
      ofs[1] = 12'($random(seed));
      ofs[2] = 12'($random(seed));
      wr_reg(6'h26, {4'h0, ofs[1]});
      wr_reg(6'h27, {4'h0, ofs[2]});
      run_temps();
      wait_temp(2'd1);
      wait_temp(2'd2);
      wr_reg(6'h00, 16'h00c0);
      rd_reg(6'h01, {4'h0, res[1]});
      rd_reg(6'h01, {4'h0, res[2]});
      wr_reg(6'h00, 16'h0041);
      rd_reg(6'h01, 16'h0000);
      rd_reg(6'h01, {4'h0, res[1]});
      rd_reg(6'h3f, 16'h0000);
      @(posedge ref_clk_i);
      shunt <= 2'b01;
      @(posedge ref_clk_i);
      shunt <= 2'b00;
      repeat (3) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(flag, 2'b01);
      rd_reg(6'h05, 16'h0001);
      sup <= 2'b10;
      wr_reg(6'h06, 16'h0003);
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(flag, 2'b10);
      @(posedge ref_clk_i);
      sup <= 2'b00;
      wr_reg(6'h06, 16'h0002);
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(flag, 2'b00);
      @(posedge ref_clk_i);
      slow <= 1'b1;
      auto <= 1'b1;
      run_temps();
      repeat (4) @(posedge ref_clk_i);
      chk(ovl, 0);
      chk(exp_q.size(), 0);
      end_of_test();
   end
endmodule
